// ### verilog/sewg_write_guard.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module sewg_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;

  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire push = in_valid_i & ~full;
  wire pop = out_ready_i & ~empty;

  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
  end

endmodule : sewg_fifo

////////////////////////////////////////////////////////////////////////////////

module sewg_write_guard #(
  parameter int unsigned WR_CYCLES = sewg_pkg::WR_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Two-wire link pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Strapped pins.
  input wire logic [2:0] chip_select_straps_i,
  input wire logic write_guard_i,
  // Nonvolatile protection backing store.
  input wire logic nv_perm_i,
  input wire logic nv_rev_i,
  output logic perm_o,
  output logic rev_o,
  // Status.
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic scl_s1_r, scl_s2_r, scl_q_r;
  logic sda_s1_r, sda_s2_r, sda_q_r;
  logic [2:0] cs_s1_r, cs_s2_r;
  logic guard_s1_r, guard_s2_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_q_r <= 1'b1;
      cs_s1_r <= 3'h0;
      cs_s2_r <= 3'h0;
      guard_s1_r <= 1'b0;
      guard_s2_r <= 1'b0;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_q_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_q_r <= sda_s2_r;
      // Floating pins are pulled low at the pad, so they arrive here as zero.
      cs_s1_r <= chip_select_straps_i;
      cs_s2_r <= cs_s1_r;
      guard_s1_r <= write_guard_i;
      guard_s2_r <= guard_s1_r;
    end
  end

  wire scl_rise = scl_s2_r & ~scl_q_r;
  wire scl_fall = ~scl_s2_r & scl_q_r;
  wire start_det = scl_s2_r & scl_q_r & sda_q_r & ~sda_s2_r;
  wire stop_det = scl_s2_r & scl_q_r & ~sda_q_r & sda_s2_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol state.

  sewg_pkg::sewg_state_t state_r, next_st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] addr_r;
  logic drive_low_r;
  logic master_nack_r;
  logic wrote_r;
  logic perm_r, rev_r;
  logic restore_done_r;
  logic [19:0] busy_cnt_r;
  logic [7:0] mem_r [sewg_pkg::MEM_DEPTH];

  wire busy = (busy_cnt_r != 20'h00000);
  wire byte_done = scl_fall & (bit_cnt_r == sewg_pkg::BYTE_BITS);
  wire ack_done = scl_fall & (bit_cnt_r == sewg_pkg::ACK_BIT);

  wire [3:0] dev_type = shift_r[7:4];
  wire cs_match = (shift_r[3:1] == cs_s2_r);
  wire dev_mem = (dev_type == sewg_pkg::DEV_TYPE_MEM) & cs_match & ~busy;
  wire dev_prot = (dev_type == sewg_pkg::DEV_TYPE_PROT) & cs_match & ~busy & ~perm_r
                  & ~shift_r[0];

  // Guard pin protects all; software bits protect only the lower half.
  wire sw_block = (perm_r | rev_r) & ~addr_r[sewg_pkg::PROT_MSB];
  wire blocked = guard_s2_r | sw_block;

  logic fifo_in_ready;
  logic fifo_out_valid;
  sewg_pkg::sewg_wr_req_t fifo_out;
  sewg_pkg::sewg_wr_req_t push_req;

  // A full buffer withholds the acknowledge of an unblocked byte so the controller sees back-pressure.
  wire wdata_ack = blocked | fifo_in_ready;
  wire ack_ok = (state_r == sewg_pkg::ST_DEV) ? (dev_mem | dev_prot) :
                (state_r == sewg_pkg::ST_WADDR) ? 1'b1 :
                (state_r == sewg_pkg::ST_WDATA) ? wdata_ack :
                (state_r == sewg_pkg::ST_PCMD) ? 1'b1 : 1'b0;
  wire push = byte_done & (state_r == sewg_pkg::ST_WDATA) & ~blocked & fifo_in_ready;
  wire rd_access = ack_done & (next_st_r == sewg_pkg::ST_RDATA);
  wire [2:0] tx_idx = 3'h7 - bit_cnt_r[2:0];

  assign push_req.addr = addr_r;
  assign push_req.data = shift_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= sewg_pkg::ST_IDLE;
      next_st_r <= sewg_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= 8'h00;
      drive_low_r <= 1'b0;
      master_nack_r <= 1'b0;
      wrote_r <= 1'b0;
    end else if (start_det) begin
      state_r <= sewg_pkg::ST_DEV;
      bit_cnt_r <= 4'h0;
      drive_low_r <= 1'b0;
      wrote_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= sewg_pkg::ST_IDLE;
      drive_low_r <= 1'b0;
      wrote_r <= 1'b0;
    end else if (state_r != sewg_pkg::ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_r < sewg_pkg::BYTE_BITS) begin
          shift_r <= {shift_r[6:0], sda_s2_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else begin
          master_nack_r <= sda_s2_r;
          bit_cnt_r <= sewg_pkg::ACK_BIT;
        end
      end else if (byte_done) begin
        if (state_r == sewg_pkg::ST_RDATA) begin
          drive_low_r <= 1'b0;
          next_st_r <= sewg_pkg::ST_RDATA;
        end else begin
          drive_low_r <= ack_ok;
          next_st_r <= sewg_pkg::ST_IDLE;
          if (ack_ok) begin
            unique case (state_r)
              sewg_pkg::ST_DEV: begin
                if (dev_prot) next_st_r <= sewg_pkg::ST_PCMD;
                else if (shift_r[0]) next_st_r <= sewg_pkg::ST_RDATA;
                else next_st_r <= sewg_pkg::ST_WADDR;
              end
              sewg_pkg::ST_WADDR: begin
                addr_r <= shift_r;
                next_st_r <= sewg_pkg::ST_WDATA;
              end
              sewg_pkg::ST_WDATA: begin
                // Only the in-page bits advance, so a long page wraps onto itself.
                addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
                wrote_r <= 1'b1;
                next_st_r <= sewg_pkg::ST_WDATA;
              end
              sewg_pkg::ST_PCMD: wrote_r <= 1'b1;
              default: next_st_r <= sewg_pkg::ST_IDLE;
            endcase
          end
        end
      end else if (ack_done) begin
        bit_cnt_r <= 4'h0;
        if (state_r == sewg_pkg::ST_RDATA && master_nack_r) begin
          state_r <= sewg_pkg::ST_IDLE;
          drive_low_r <= 1'b0;
        end else begin
          state_r <= next_st_r;
          if (next_st_r == sewg_pkg::ST_RDATA) begin
            tx_r <= mem_r[addr_r];
            drive_low_r <= ~mem_r[addr_r][7];
            addr_r <= addr_r + 8'h01;
          end else begin
            drive_low_r <= 1'b0;
          end
        end
      end else if (scl_fall && state_r == sewg_pkg::ST_RDATA) begin
        drive_low_r <= ~tx_r[tx_idx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protection bits and write cycle timer.

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      perm_r <= 1'b0;
      rev_r <= 1'b0;
      restore_done_r <= 1'b0;
    end else if (!restore_done_r) begin
      // Bits come back from the backing store on the first edge after reset.
      perm_r <= nv_perm_i;
      rev_r <= nv_rev_i;
      restore_done_r <= 1'b1;
    end else if (byte_done && state_r == sewg_pkg::ST_PCMD) begin
      // No command path ever clears the permanent bit.
      if (shift_r == sewg_pkg::PCMD_SET_PERM) perm_r <= 1'b1;
      if (shift_r == sewg_pkg::PCMD_SET_REV) rev_r <= 1'b1;
      if (shift_r == sewg_pkg::PCMD_CLR_REV) rev_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_r <= 20'h00000;
    end else if (stop_det && wrote_r) begin
      busy_cnt_r <= WR_CYCLES[19:0];
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r - 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write buffer and array.

  // The array port is shared with read fetches, which take priority.
  sewg_fifo #(
    .WIDTH($bits(sewg_pkg::sewg_wr_req_t)),
    .DEPTH(sewg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_req),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(~rd_access),
    .out_data_o(fifo_out)
  );

  always_ff @(posedge core_clk_i) begin
    if (fifo_out_valid && !rd_access) mem_r[fifo_out.addr] <= fifo_out.data;
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drive_low_r;
  assign perm_o = perm_r;
  assign rev_o = rev_r;
  assign busy_o = busy;

endmodule : sewg_write_guard

// ### include/sewg_pkg.sv
package sewg_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_WR_NS = 5000000;
  // A longest time, so the division rounds down.
  localparam int unsigned WR_CYCLES = T_WR_NS / CLK_PERIOD_NS;

  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned PAGE_BITS = 4;
  localparam int unsigned PROT_MSB = 7;
  localparam int unsigned FIFO_DEPTH = 8;

  localparam logic [3:0] DEV_TYPE_MEM = 4'hA;
  localparam logic [3:0] DEV_TYPE_PROT = 4'h6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;

  localparam logic [7:0] PCMD_SET_REV = 8'h01;
  localparam logic [7:0] PCMD_CLR_REV = 8'h02;
  localparam logic [7:0] PCMD_SET_PERM = 8'h04;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_PCMD = 3'b100,
    ST_RDATA = 3'b101
  } sewg_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sewg_wr_req_t;

endpackage : sewg_pkg

// ### sim/sewg_asserts.sv
`timescale 1ns/1ps

module sewg_asserts #(
  parameter int unsigned WR_CYCLES = 200
) (
  // Clock, reset and link.
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  // Straps and protection state.
  input wire logic [2:0] chip_select_straps_i,
  input wire logic write_guard_i,
  input wire logic nv_perm_i,
  input wire logic nv_rev_i,
  input wire logic perm_o,
  input wire logic rev_o,
  input wire logic busy_o
);
  int unsigned busy_cnt_r;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_o ? busy_cnt_r + 1 : 0;
  sequence drive_s; $fell(sda_oe_n_o); endsequence
  sequence hold_s; !sda_oe_n_o [*8]; endsequence
  sda_low_a: assert property (sda_o == 1'b0) else $error("data not low");
  ack_hold_a: assert property (drive_s |-> hold_s) else $error("drive short");
  drv_lowclk_a: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("drive change in clock high");
  wr_time_a: assert property ($fell(busy_o) |-> busy_cnt_r == WR_CYCLES)
    else $error("write time wrong");
  busy_mute_a: assert property (busy_o |-> sda_oe_n_o) else $error("drive when busy");
  busy_stop_a: assert property ($rose(busy_o) |-> scl_i && sda_i) else $error("busy early");
  nv_load_a: assert property ($fell(reset_i) |=> perm_o == $past(nv_perm_i)
    && rev_o == $past(nv_rev_i)) else $error("restore wrong");
  perm_keep_a: assert property (perm_o |=> perm_o) else $error("permanent cleared");
endmodule : sewg_asserts

// ### sim/sewg_ctl.sv
`timescale 1ns/1ps

module sewg_ctl (
  // Wire level of the data line.
  input wire logic sda_i,
  // Clock and data release; a released line goes to the pull-up.
  output logic scl_o,
  output logic sda_rel_o
);
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  task automatic bit_x(input logic b, output logic r);
    #40 sda_rel_o = b;
    #40 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
  endtask : bit_x
  task automatic start;
    #40 sda_rel_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_rel_o = 1'b0;
    #40 scl_o = 1'b0;
  endtask : start
  task automatic stop;
    #40 sda_rel_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_rel_o = 1'b1;
    #40;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~more, r);
  endtask : rbyte
endmodule : sewg_ctl

// ### sim/sewg_write_guard_tb.sv
`timescale 1ns/1ps

module sewg_write_guard_tb;
  localparam int unsigned WR = 300;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] chip_select_straps_i = 3'h5;
  logic write_guard_i = 1'b0;
  logic nv_perm_i = 1'b0;
  logic nv_rev_i = 1'b0;
  logic scl_i, sda_o, sda_oe_n_o, perm_o, rev_o, busy_o, rel, ok, rst_q;
  logic [7:0] got;
  int err_total = 0;
  int checks = 0;
  wire logic sda_i = rel & (sda_oe_n_o | sda_o);
  sewg_write_guard #(.WR_CYCLES(WR)) u_sewg_write_guard (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .chip_select_straps_i(chip_select_straps_i),
    .write_guard_i(write_guard_i),
    .nv_perm_i(nv_perm_i),
    .nv_rev_i(nv_rev_i),
    .perm_o(perm_o),
    .rev_o(rev_o),
    .busy_o(busy_o)
  );
  sewg_ctl u_sewg_ctl (.sda_i(sda_i), .scl_o(scl_i), .sda_rel_o(rel));
  initial forever #5 core_clk_i = ~core_clk_i;
  // The store skips the restoring edge, so it never sees the cleared flags.
  always @(posedge core_clk_i) rst_q <= reset_i;
  always @(posedge core_clk_i) if (!reset_i && !rst_q) {nv_perm_i, nv_rev_i} <= {perm_o, rev_o};
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // The first cycles are waited out so that a write timer has time to start.
  task automatic wait_idle;
    for (int i = 0; i < 1000 && (i < 12 || busy_o !== 1'b0); i++) tick(1);
    check({7'h0, busy_o}, 8'h00);
    if (busy_o !== 1'b0) complete_run();
  endtask : wait_idle
  task automatic xfer(input logic [7:0] w, a, d, input int n);
    logic k;
    u_sewg_ctl.start();
    u_sewg_ctl.wbyte(w, ok);
    for (int i = -1; i < n && ok === 1'b1; i++) begin
      u_sewg_ctl.wbyte(i < 0 ? a : d + 8'(i), k);
      ok = k;
    end
    u_sewg_ctl.stop();
  endtask : xfer
  task automatic wr(input logic [7:0] w, a, d, input int n, input logic e);
    xfer(w, a, d, n);
    check({7'h0, ok}, {7'h0, e});
    wait_idle();
  endtask : wr
  task automatic rdc(input logic [7:0] a, e);
    logic k;
    u_sewg_ctl.start();
    u_sewg_ctl.wbyte(8'hAA, k);
    u_sewg_ctl.wbyte(a, k);
    u_sewg_ctl.start();
    u_sewg_ctl.wbyte(8'hAB, k);
    u_sewg_ctl.rbyte(1'b0, got);
    u_sewg_ctl.stop();
    check(got, e);
  endtask : rdc
  // A held acknowledge keeps the read going past the page end.
  task automatic t_seq;
    logic k;
    u_sewg_ctl.start();
    u_sewg_ctl.wbyte(8'hAA, k);
    u_sewg_ctl.wbyte(8'h7F, k);
    u_sewg_ctl.start();
    u_sewg_ctl.wbyte(8'hAB, k);
    u_sewg_ctl.rbyte(1'b1, got);
    check(got, 8'h66);
    u_sewg_ctl.rbyte(1'b0, got);
    check(got, 8'h77);
    u_sewg_ctl.stop();
    $display("end sequential");
  endtask : t_seq
  task automatic t_select;
    for (int s = 0; s < 8; s++) wr({4'hA, 3'(s), 1'b0}, 8'h00, 8'h00, -1, s == 5);
    wr(8'h3A, 8'h00, 8'h00, -1, 1'b0);
    wr(8'h6B, 8'h00, 8'h00, -1, 1'b0);
    $display("end select");
  endtask : t_select
  task automatic t_page;
    xfer(8'hAA, 8'h8E, 8'h40, 3);
    wr(8'hAA, 8'h00, 8'h00, -1, 1'b0);
    wr(8'hAA, 8'h7F, 8'h20, 2, 1'b1);
    rdc(8'h80, 8'h42);
    rdc(8'h8F, 8'h41);
    rdc(8'h70, 8'h21);
    $display("end page");
  endtask : t_page
  task automatic t_guard;
    write_guard_i = 1'b1;
    wr(8'hAA, 8'h80, 8'h55, 1, 1'b1);
    rdc(8'h80, 8'h42);
    write_guard_i = 1'b0;
    $display("end guard");
  endtask : t_guard
  task automatic t_soft;
    wr(8'h6A, 8'h01, 8'h00, 0, 1'b1);
    check({6'h0, perm_o, rev_o}, 8'h01);
    wr(8'hAA, 8'h7F, 8'h66, 1, 1'b1);
    wr(8'hAA, 8'h80, 8'h77, 1, 1'b1);
    rdc(8'h7F, 8'h20);
    rdc(8'h80, 8'h77);
    wr(8'h6A, 8'h02, 8'h00, 0, 1'b1);
    check({6'h0, perm_o, rev_o}, 8'h00);
    wr(8'hAA, 8'h7F, 8'h66, 1, 1'b1);
    rdc(8'h7F, 8'h66);
    wr(8'h6A, 8'h04, 8'h00, 0, 1'b1);
    check({6'h0, perm_o, rev_o}, 8'h02);
    wr(8'h6A, 8'h02, 8'h00, 0, 1'b0);
    wr(8'hAA, 8'h7F, 8'h99, 1, 1'b1);
    rdc(8'h7F, 8'h66);
    write_guard_i = 1'b1;
    wr(8'hAA, 8'h80, 8'h11, 1, 1'b1);
    rdc(8'h80, 8'h77);
    write_guard_i = 1'b0;
    $display("end soft");
  endtask : t_soft
  task automatic t_nv;
    reset_i = 1'b1;
    tick(5);
    reset_i = 1'b0;
    tick(2);
    check({6'h0, perm_o, rev_o}, 8'h02);
    tick(4);
    wr(8'h6A, 8'h02, 8'h00, 0, 1'b0);
    $display("end restore");
  endtask : t_nv
  initial begin
    tick(5);
    reset_i = 1'b0;
    tick(6);
    t_select();
    t_page();
    t_guard();
    t_soft();
    t_seq();
    t_nv();
    complete_run();
  end
endmodule : sewg_write_guard_tb

bind sewg_write_guard sewg_asserts #(.WR_CYCLES(WR_CYCLES)) u_sewg_asserts (
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o),
  .chip_select_straps_i(chip_select_straps_i),
  .write_guard_i(write_guard_i),
  .nv_perm_i(nv_perm_i),
  .nv_rev_i(nv_rev_i),
  .perm_o(perm_o),
  .rev_o(rev_o),
  .busy_o(busy_o)
);
